// [design/fpec_ctrl.sv]
`timescale 1ns/1ns
`include "fpec_defines.svh"
// How it works
// - Erase-setup takes a one only when hw and sw enables are one.
// - Program-setup takes a one only when hw and sw enables are one.
// - Erase-verify bit enters/leaves erase-verify; set needs both enables.
// - Program-verify bit enters/leaves program-verify; set needs both enables.
// - Erase trigger sets only with both enables and erase-setup one.
// - Program trigger sets only with both enables and program-setup one.
// - Status is read-only, zero after reset/hw standby, zero if flash disabled.
// - Flash array reads during program/erase set the fault flag.
// - Non-excluded exception start during program/erase sets fault flag.
// - Sleep or bus release during program/erase sets fault flag.
// - Fault flag blocks program/erase; only reset or hw standby clears.
// - Status bits six to zero read zero.
// - Block select clears on reset, standby, hw enable low, permit zero.
// - Only selected blocks are erased; others protected.
// - Block-select ones are ignored until the permit bit is set.
// - Block select writable only in modes 5 and 7, else zeros.
// - Select bits map to fixed 1k, 28k and 32k address blocks.
// - Top control bit mirrors the hardware write-enable pin.
// - Permit bit takes a one only while hw enable is one.
// - Mode control clears on reset and both standby modes.
module fpec_ctrl
(
	// Clock and reset
	input  wire logic                   clk_sys,
	input  wire logic                   resetn,
	// Pins
	input  wire logic                   hw_write_enable,
	input  wire logic                   wdt_resetn,
	// CPU events and array address
	input  wire fpec_pkg::fpec_cpu_evt_t cpu_evt,
	input  wire logic [16:0]            flash_addr,
	// Flash array control
	output logic [2:0]                  flash_mode,
	output logic                        flash_erase_sel,
	output logic [7:0]                  block_enable,
	// AXI4-Lite write address and data
	input  wire logic [7:0]             s_axi_awaddr,
	input  wire logic                   s_axi_awvalid,
	output logic                        s_axi_awready,
	input  wire logic [31:0]            s_axi_wdata,
	input  wire logic [3:0]             s_axi_wstrb,
	input  wire logic                   s_axi_wvalid,
	output logic                        s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]                  s_axi_bresp,
	output logic                        s_axi_bvalid,
	input  wire logic                   s_axi_bready,
	// AXI4-Lite read
	input  wire logic [7:0]             s_axi_araddr,
	input  wire logic                   s_axi_arvalid,
	output logic                        s_axi_arready,
	output logic [31:0]                 s_axi_rdata,
	output logic [1:0]                  s_axi_rresp,
	output logic                        s_axi_rvalid,
	input  wire logic                   s_axi_rready
);
	import fpec_pkg::*;

	// Every check in this module runs on the system clock, idle in reset.
	default clocking cb_sys @(posedge clk_sys);
	endclocking
	default disable iff (!resetn);

	logic       hwe_meta_ff;
	logic       hwe_ff;
	logic       wdt_meta_ff;
	logic       wdt_n_ff;
	fpec_ctrl_t ctrl_ff;
	logic       fault_ff;
	logic [7:0] blk_ff;
	logic       hstby_ff;
	logic       sstby_ff;
	logic [2:0] chip_mode_ff;
	logic [7:0] aw_addr_ff;
	logic       aw_have_ff;
	logic [31:0] w_data_ff;
	logic       w_strb0_ff;
	logic       w_have_ff;
	logic       wr_go;
	logic [7:0] wbyte;
	logic       busy;
	logic       flash_on;
	logic       perm;
	logic       blk_mode_ok;
	logic       fault_evt;
	logic       stby;
	logic       fault_clr;
	fpec_mode_t nxt_mode;
	logic [7:0] nxt_blk;
	logic [31:0] nxt_rdata;
	logic       nxt_rerr;

	// Chip modes 5 to 7 have the on-chip flash enabled.
	function automatic logic flash_enabled(input logic [2:0] m);
		flash_enabled = (m == 3'h5) || (m == 3'h6) || (m == 3'h7);
	endfunction

	// Address block lookup, used for the erase select output.
	function automatic logic [2:0] block_of(input logic [16:0] a);
		if (a >= `FPEC_BLK7_BASE)
			block_of = 3'h7;
		else if (a >= `FPEC_BLK6_BASE)
			block_of = 3'h6;
		else if (a >= `FPEC_BLK5_BASE)
			block_of = 3'h5;
		else if (a >= `FPEC_BLK4_BASE)
			block_of = 3'h4;
		else if (a >= `FPEC_BLK3_BASE)
			block_of = 3'h3;
		else if (a >= `FPEC_BLK2_BASE)
			block_of = 3'h2;
		else if (a >= `FPEC_BLK1_BASE)
			block_of = 3'h1;
		else
			block_of = 3'h0;
	endfunction

	// Pins are asynchronous; two flops before any use.
	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
		begin
			hwe_meta_ff <= 1'b0;
			hwe_ff      <= 1'b0;
			wdt_meta_ff <= 1'b1;
			wdt_n_ff    <= 1'b1;
		end
		else
		begin
			hwe_meta_ff <= hw_write_enable;
			hwe_ff      <= hwe_meta_ff;
			wdt_meta_ff <= wdt_resetn;
			wdt_n_ff    <= wdt_meta_ff;
		end
	end

	assign wr_go       = aw_have_ff && w_have_ff && !s_axi_bvalid;
	// Only the low byte lane carries a register; other lanes are ignored.
	assign wbyte       = w_strb0_ff ? w_data_ff[7:0] : ctrl_ff;
	assign busy        = ctrl_ff.erase_run || ctrl_ff.program_run;
	assign flash_on    = flash_enabled(chip_mode_ff);
	assign perm        = hwe_ff && ctrl_ff.sw_write_permit;
	assign stby        = hstby_ff || sstby_ff;
	assign fault_clr   = !wdt_n_ff || hstby_ff;
	assign blk_mode_ok = (chip_mode_ff == 3'h5) || (chip_mode_ff == 3'h7);
	assign fault_evt   = busy && (
		(cpu_evt.flash_read && !cpu_evt.overlap_ram_read) ||
		(cpu_evt.exception_start && !cpu_evt.exception_excluded) ||
		cpu_evt.sleep_exec || cpu_evt.bus_release);

	// AXI write channels are taken independently and held until both exist.
	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
		begin
			aw_have_ff    <= 1'b0;
			w_have_ff     <= 1'b0;
			aw_addr_ff    <= 8'h00;
			w_data_ff     <= 32'h00000000;
			w_strb0_ff    <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `FPEC_RESP_OKAY;
		end
		else
		begin
			s_axi_awready <= !aw_have_ff && !s_axi_awready;
			s_axi_wready  <= !w_have_ff && !s_axi_wready;
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_have_ff <= 1'b1;
				aw_addr_ff <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_have_ff  <= 1'b1;
				w_data_ff  <= s_axi_wdata;
				w_strb0_ff <= s_axi_wstrb[0];
				s_axi_wready <= 1'b0;
			end
			if (wr_go)
			begin
				aw_have_ff   <= 1'b0;
				w_have_ff    <= 1'b0;
				s_axi_bvalid <= 1'b1;
				case (aw_addr_ff)
				`FPEC_OFS_MODE_CTRL,
				`FPEC_OFS_FAULT_STAT,
				`FPEC_OFS_BLOCK_SEL,
				`FPEC_OFS_SYS_CTRL:
					s_axi_bresp <= `FPEC_RESP_OKAY;
				default:
					s_axi_bresp <= `FPEC_RESP_SLVERR;
				endcase
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// Standby and chip mode live in a system control word.
	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
		begin
			hstby_ff     <= 1'b0;
			sstby_ff     <= 1'b0;
			chip_mode_ff <= `FPEC_RST_CHIPMODE;
		end
		else if (wr_go && aw_addr_ff == `FPEC_OFS_SYS_CTRL && w_strb0_ff)
		begin
			hstby_ff     <= w_data_ff[`FPEC_BIT_HSTBY];
			sstby_ff     <= w_data_ff[`FPEC_BIT_SSTBY];
			chip_mode_ff <= w_data_ff[`FPEC_LSB_CHIPMODE +: 3];
		end
	end

	// Mode control: bits 5 to 0 check their own enables against the old state.
	always_ff @(posedge clk_sys)
	begin
		if (!resetn || stby)
			ctrl_ff <= `FPEC_RST_BYTE;
		else
		begin
			ctrl_ff.hw_write_enable <= hwe_ff;
			if (!hwe_ff)
				ctrl_ff[6:0] <= 7'h00;
			else if (wr_go && aw_addr_ff == `FPEC_OFS_MODE_CTRL && w_strb0_ff
				&& flash_on)
			begin
				ctrl_ff.sw_write_permit <= wbyte[`FPEC_BIT_SWP];
				ctrl_ff.erase_setup <= wbyte[`FPEC_BIT_ESET] && perm;
				ctrl_ff.program_setup <= wbyte[`FPEC_BIT_PSET] && perm;
				ctrl_ff.erase_verify_select <= wbyte[`FPEC_BIT_EVS] && perm;
				ctrl_ff.program_verify_select <=
					wbyte[`FPEC_BIT_PVS] && perm;
				ctrl_ff.erase_run <= wbyte[`FPEC_BIT_ERS] && perm
					&& ctrl_ff.erase_setup;
				ctrl_ff.program_run <= wbyte[`FPEC_BIT_PRG] && perm
					&& ctrl_ff.program_setup;
			end
		end
	end

	// Fault flag: set wins; software standby leaves it alone.
	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
			fault_ff <= 1'b0;
		else if (fault_evt)
			fault_ff <= 1'b1;
		else if (fault_clr)
			fault_ff <= 1'b0;
	end

	always_comb
	begin
		nxt_blk = blk_ff;
		if (!hwe_ff || !ctrl_ff.sw_write_permit || !blk_mode_ok)
			nxt_blk = 8'h00;
		else if (wr_go && aw_addr_ff == `FPEC_OFS_BLOCK_SEL && w_strb0_ff)
			nxt_blk = w_data_ff[7:0];
	end

	always_ff @(posedge clk_sys)
	begin
		if (!resetn || stby)
			blk_ff <= 8'h00;
		else
			blk_ff <= nxt_blk;
	end

	// The array mode: error protection overrides every request.
	always_comb
	begin
		if (fault_ff)
			nxt_mode = FPEC_ERRPROT;
		else if (ctrl_ff.erase_run)
			nxt_mode = FPEC_ERASE;
		else if (ctrl_ff.program_run)
			nxt_mode = FPEC_PROGRAM;
		else if (ctrl_ff.erase_verify_select)
			nxt_mode = FPEC_EVERIFY;
		else if (ctrl_ff.program_verify_select)
			nxt_mode = FPEC_PVERIFY;
		else
			nxt_mode = FPEC_USER;
	end

	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
		begin
			flash_mode      <= FPEC_USER;
			block_enable    <= 8'h00;
			flash_erase_sel <= 1'b0;
		end
		else
		begin
			flash_mode <= nxt_mode;
			block_enable <= (nxt_mode == FPEC_ERASE) ? blk_ff : 8'h00;
			flash_erase_sel <= blk_ff[block_of(flash_addr)]
				&& (nxt_mode == FPEC_ERASE);
		end
	end

	always_comb
	begin
		nxt_rerr  = 1'b0;
		nxt_rdata = 32'h00000000;
		case (s_axi_araddr)
		`FPEC_OFS_MODE_CTRL:
			nxt_rdata[7:0] = flash_on ? ctrl_ff : 8'h00;
		`FPEC_OFS_FAULT_STAT:
			nxt_rdata[7:0] = (flash_on ? {fault_ff, 7'h00} : 8'h00);
		`FPEC_OFS_BLOCK_SEL:
			nxt_rdata[7:0] = blk_ff;
		`FPEC_OFS_SYS_CTRL:
			nxt_rdata[7:0] = {1'b0, chip_mode_ff, 2'h0, sstby_ff, hstby_ff};
		default:
			nxt_rerr = 1'b1;
		endcase
	end

	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= `FPEC_RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= nxt_rdata;
			s_axi_rresp   <= nxt_rerr ? `FPEC_RESP_SLVERR : `FPEC_RESP_OKAY;
		end
		else if (s_axi_rvalid)
		begin
			if (s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
		else
			s_axi_arready <= !s_axi_arready && s_axi_arvalid;
	end

	// A fault shows in the flag first and in the array mode one cycle later.
	sequence s_fault_prot;
		fault_ff ##1 flash_mode == FPEC_ERRPROT;
	endsequence

	a_setup_gated: assert property (
		$rose(ctrl_ff.erase_setup) |-> $past(perm))
		else $error("erase setup rose without enables");
	a_psetup_gated: assert property (
		$rose(ctrl_ff.program_setup) |-> $past(perm))
		else $error("program setup rose without enables");
	a_erase_needs: assert property (
		$rose(ctrl_ff.erase_run) |-> $past(ctrl_ff.erase_setup))
		else $error("erase started without setup");
	a_prog_needs: assert property (
		$rose(ctrl_ff.program_run) |-> $past(ctrl_ff.program_setup))
		else $error("program started without setup");
	a_fault_set: assert property (
		busy && cpu_evt.bus_release |=> s_fault_prot)
		else $error("bus release did not raise fault");
	a_fault_sticky: assert property (
		fault_ff && wdt_n_ff && !hstby_ff |=> fault_ff)
		else $error("fault flag cleared without reset");
	a_blk_clear: assert property (
		!hwe_ff |=> blk_ff == 8'h00)
		else $error("block select held with write enable low");
	a_hwe_mirror: assert property (
		!stby |=> ctrl_ff.hw_write_enable == $past(hwe_ff))
		else $error("top control bit does not follow pin");

endmodule // fpec_ctrl

// [design/fpec_defines.svh]
`ifndef FPEC_DEFINES_SVH
`define FPEC_DEFINES_SVH

// Byte addresses of the registers on the AXI4-Lite slave.
`define FPEC_OFS_MODE_CTRL    8'h00
`define FPEC_OFS_FAULT_STAT   8'h04
`define FPEC_OFS_BLOCK_SEL    8'h08
`define FPEC_OFS_SYS_CTRL     8'h0C

// Field positions in flash_mode_control.
`define FPEC_BIT_HWE          7
`define FPEC_BIT_SWP          6
`define FPEC_BIT_ESET         5
`define FPEC_BIT_PSET         4
`define FPEC_BIT_EVS          3
`define FPEC_BIT_PVS          2
`define FPEC_BIT_ERS          1
`define FPEC_BIT_PRG          0

// Field positions in flash_fault_status.
`define FPEC_BIT_FAULT        7

// Field positions in sys_control (standby and chip mode).
`define FPEC_BIT_HSTBY        0
`define FPEC_BIT_SSTBY        1
`define FPEC_LSB_CHIPMODE     4

`define FPEC_RST_BYTE         8'h00
`define FPEC_RST_CHIPMODE     3'h7

// Block base addresses, bits 0 to 7.
`define FPEC_BLK0_BASE        17'h00000
`define FPEC_BLK1_BASE        17'h00400
`define FPEC_BLK2_BASE        17'h00800
`define FPEC_BLK3_BASE        17'h00C00
`define FPEC_BLK4_BASE        17'h01000
`define FPEC_BLK5_BASE        17'h08000
`define FPEC_BLK6_BASE        17'h10000
`define FPEC_BLK7_BASE        17'h18000
`define FPEC_FLASH_TOP        17'h1FFFF

`define FPEC_RESP_OKAY        2'h0
`define FPEC_RESP_SLVERR      2'h2

`endif

// [design/fpec_pkg.sv]
package fpec_pkg;

	typedef enum logic [2:0]
	{
		FPEC_USER      = 3'h0,
		FPEC_PROGRAM   = 3'h1,
		FPEC_ERASE     = 3'h2,
		FPEC_PVERIFY   = 3'h3,
		FPEC_EVERIFY   = 3'h4,
		FPEC_ERRPROT   = 3'h5
	} fpec_mode_t;

	typedef struct packed
	{
		logic        hw_write_enable;
		logic        sw_write_permit;
		logic        erase_setup;
		logic        program_setup;
		logic        erase_verify_select;
		logic        program_verify_select;
		logic        erase_run;
		logic        program_run;
	} fpec_ctrl_t;

	// CPU events that may hit a running program or erase.
	typedef struct packed
	{
		logic        flash_read;
		logic        overlap_ram_read;
		logic        exception_start;
		logic        exception_excluded;
		logic        sleep_exec;
		logic        bus_release;
	} fpec_cpu_evt_t;

endpackage

// [sim/test_flash_program_erase_control.sv]
`timescale 1ns/1ns
`include "fpec_defines.svh"
module test_flash_program_erase_control;
	import fpec_pkg::*;

	logic                clk_sys;
	logic                resetn;
	logic                hw_write_enable;
	logic                wdt_resetn;
	fpec_cpu_evt_t       cpu_evt;
	logic [16:0]         flash_addr;
	logic [2:0]          flash_mode;
	logic                flash_erase_sel;
	logic [7:0]          block_enable;
	logic [7:0]          awaddr;
	logic                awvalid;
	logic                awready;
	logic [31:0]         wdata;
	logic [3:0]          wstrb;
	logic                wvalid;
	logic                wready;
	logic [1:0]          bresp;
	logic                bvalid;
	logic                bready;
	logic [7:0]          araddr;
	logic                arvalid;
	logic                arready;
	logic [31:0]         rdata;
	logic [1:0]          rresp;
	logic                rvalid;
	logic                rready;
	int                  fails;
	int                  cmp_count;

	fpec_ctrl DUT
	(
		.clk_sys(clk_sys), .resetn(resetn),
		.hw_write_enable(hw_write_enable), .wdt_resetn(wdt_resetn),
		.cpu_evt(cpu_evt), .flash_addr(flash_addr),
		.flash_mode(flash_mode), .flash_erase_sel(flash_erase_sel),
		.block_enable(block_enable),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready)
	);

	always #25 clk_sys = ~clk_sys;

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			fails++;
			$display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		int n;
		logic aw_done;
		logic w_done;
		n = 0;
		aw_done = 1'b0;
		w_done = 1'b0;
		@(posedge clk_sys);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= {24'h000000, d};
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(aw_done && w_done) && n < 200)
		begin
			@(posedge clk_sys);
			n++;
			if (awvalid && awready === 1'b1)
			begin
				awvalid <= 1'b0;
				aw_done = 1'b1;
			end
			if (wvalid && wready === 1'b1)
			begin
				wvalid <= 1'b0;
				w_done = 1'b1;
			end
		end
		do @(posedge clk_sys);
		while (bvalid !== 1'b1 && ++n < 200);
		bready <= 1'b0;
		if (n >= 200)
			chk(32'h1, 32'h0);
		chk({30'h0, bresp},
			{30'h0, (a > 8'h0C) ? `FPEC_RESP_SLVERR : `FPEC_RESP_OKAY});
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		int n;
		n = 0;
		@(posedge clk_sys);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge clk_sys);
		while (arready !== 1'b1 && ++n < 200);
		arvalid <= 1'b0;
		do @(posedge clk_sys);
		while (rvalid !== 1'b1 && ++n < 200);
		rready <= 1'b0;
		if (n >= 200)
			chk(32'h1, 32'h0);
		chk(rdata, {24'h000000, exp});
		chk({30'h0, rresp},
			{30'h0, (a > 8'h0C) ? `FPEC_RESP_SLVERR : `FPEC_RESP_OKAY});
	endtask

	task automatic mode_is(input logic [2:0] exp);
		repeat (3) @(posedge clk_sys);
		chk({29'h0, flash_mode}, {29'h0, exp});
	endtask

	task automatic pin_wait();
		repeat (4) @(posedge clk_sys);
	endtask

	task automatic t_reset_and_map();
		rd(`FPEC_OFS_MODE_CTRL, 8'h00);
		rd(`FPEC_OFS_FAULT_STAT, 8'h00);
		rd(`FPEC_OFS_BLOCK_SEL, 8'h00);
		wr(8'h10, 8'h40);
		rd(8'h10, 8'h00);
		wr(`FPEC_OFS_MODE_CTRL, 8'h40);
		rd(`FPEC_OFS_MODE_CTRL, 8'h00);
		@(posedge clk_sys) hw_write_enable <= 1'b1;
		pin_wait();
		rd(`FPEC_OFS_MODE_CTRL, 8'h80);
		// A write without the low byte lane must leave the permit bit clear.
		wstrb <= 4'hE;
		wr(`FPEC_OFS_MODE_CTRL, 8'h40);
		rd(`FPEC_OFS_MODE_CTRL, 8'h80);
		wstrb <= 4'hF;
	endtask

	task automatic t_mode_gating();
		wr(`FPEC_OFS_MODE_CTRL, 8'h20);
		rd(`FPEC_OFS_MODE_CTRL, 8'h80);
		wr(`FPEC_OFS_MODE_CTRL, 8'h10);
		rd(`FPEC_OFS_MODE_CTRL, 8'h80);
		wr(`FPEC_OFS_MODE_CTRL, 8'h40);
		rd(`FPEC_OFS_MODE_CTRL, 8'hC0);
		wr(`FPEC_OFS_MODE_CTRL, 8'h42);
		mode_is(FPEC_USER);
		wr(`FPEC_OFS_MODE_CTRL, 8'h60);
		wr(`FPEC_OFS_MODE_CTRL, 8'h62);
		rd(`FPEC_OFS_MODE_CTRL, 8'hE2);
		mode_is(FPEC_ERASE);
		wr(`FPEC_OFS_MODE_CTRL, 8'h60);
		mode_is(FPEC_USER);
		wr(`FPEC_OFS_MODE_CTRL, 8'h41);
		rd(`FPEC_OFS_MODE_CTRL, 8'hC0);
		wr(`FPEC_OFS_MODE_CTRL, 8'h50);
		wr(`FPEC_OFS_MODE_CTRL, 8'h51);
		mode_is(FPEC_PROGRAM);
		wr(`FPEC_OFS_MODE_CTRL, 8'h40);
		wr(`FPEC_OFS_MODE_CTRL, 8'h48);
		mode_is(FPEC_EVERIFY);
		wr(`FPEC_OFS_MODE_CTRL, 8'h40);
		mode_is(FPEC_USER);
		wr(`FPEC_OFS_MODE_CTRL, 8'h44);
		mode_is(FPEC_PVERIFY);
		wr(`FPEC_OFS_SYS_CTRL, 8'h72);
		wr(`FPEC_OFS_SYS_CTRL, 8'h70);
		rd(`FPEC_OFS_MODE_CTRL, 8'h80);
		mode_is(FPEC_USER);
	endtask

	task automatic t_block_select();
		logic [16:0] base [8];
		base = '{17'h00000, 17'h00400, 17'h00800, 17'h00C00,
			17'h01000, 17'h08000, 17'h10000, 17'h18000};
		wr(`FPEC_OFS_BLOCK_SEL, 8'h01);
		rd(`FPEC_OFS_BLOCK_SEL, 8'h00);
		wr(`FPEC_OFS_MODE_CTRL, 8'h40);
		wr(`FPEC_OFS_SYS_CTRL, 8'h60);
		wr(`FPEC_OFS_BLOCK_SEL, 8'h01);
		rd(`FPEC_OFS_BLOCK_SEL, 8'h00);
		wr(`FPEC_OFS_SYS_CTRL, 8'h70);
		wr(`FPEC_OFS_BLOCK_SEL, 8'h04);
		rd(`FPEC_OFS_BLOCK_SEL, 8'h04);
		wr(`FPEC_OFS_MODE_CTRL, 8'h00);
		rd(`FPEC_OFS_BLOCK_SEL, 8'h00);
		wr(`FPEC_OFS_MODE_CTRL, 8'h40);
		wr(`FPEC_OFS_BLOCK_SEL, 8'h01);
		repeat (3) @(posedge clk_sys);
		chk({24'h0, block_enable}, 32'h0);
		wr(`FPEC_OFS_MODE_CTRL, 8'h60);
		wr(`FPEC_OFS_MODE_CTRL, 8'h62);
		for (int i = 0; i < 8; i++)
		begin
			wr(`FPEC_OFS_BLOCK_SEL, 8'(1 << i));
			flash_addr <= base[i];
			repeat (3) @(posedge clk_sys);
			chk({24'h0, block_enable}, 32'(1 << i));
			chk({31'h0, flash_erase_sel}, 32'h1);
			flash_addr <= (i == 7) ? 17'h1FFFF : base[i + 1] - 17'h00001;
			repeat (3) @(posedge clk_sys);
			chk({31'h0, flash_erase_sel}, 32'h1);
			flash_addr <= (i == 0) ? base[1] : base[i] - 17'h00001;
			repeat (3) @(posedge clk_sys);
			chk({31'h0, flash_erase_sel}, 32'h0);
		end
		wr(`FPEC_OFS_MODE_CTRL, 8'h60);
		@(posedge clk_sys) hw_write_enable <= 1'b0;
		pin_wait();
		rd(`FPEC_OFS_BLOCK_SEL, 8'h00);
		@(posedge clk_sys) hw_write_enable <= 1'b1;
		pin_wait();
		wr(`FPEC_OFS_BLOCK_SEL, 8'h00);
	endtask

	task automatic t_fault_events();
		logic [5:0] evt [6];
		logic [5:0] hit;
		// The overlap case also raises flash_read, so its exclusion counts.
		evt = '{6'b100000, 6'b110000, 6'b001000, 6'b001100,
			6'b000010, 6'b000001};
		hit = 6'b101011;
		for (int i = 0; i < 6; i++)
		begin
			wr(`FPEC_OFS_MODE_CTRL, 8'h40);
			wr(`FPEC_OFS_MODE_CTRL, 8'h50);
			wr(`FPEC_OFS_MODE_CTRL, 8'h51);
			@(posedge clk_sys) cpu_evt <= evt[i];
			@(posedge clk_sys) cpu_evt <= '0;
			rd(`FPEC_OFS_FAULT_STAT,
				hit[5 - i] ? 8'h80 : 8'h00);
			mode_is(hit[5 - i] ? FPEC_ERRPROT : FPEC_PROGRAM);
			if (i == 0)
			begin
				wr(`FPEC_OFS_FAULT_STAT, 8'h00);
				rd(`FPEC_OFS_FAULT_STAT, 8'h80);
				wr(`FPEC_OFS_MODE_CTRL, 8'h50);
				wr(`FPEC_OFS_MODE_CTRL, 8'h51);
				mode_is(FPEC_ERRPROT);
				wr(`FPEC_OFS_SYS_CTRL, 8'h40);
				rd(`FPEC_OFS_FAULT_STAT, 8'h00);
				wr(`FPEC_OFS_SYS_CTRL, 8'h70);
				rd(`FPEC_OFS_FAULT_STAT, 8'h80);
			end
			// Alternate the two clearing paths so each is exercised.
			if (i % 2 == 0)
			begin
				@(posedge clk_sys) wdt_resetn <= 1'b0;
				pin_wait();
				wdt_resetn <= 1'b1;
				pin_wait();
			end
			else
			begin
				wr(`FPEC_OFS_SYS_CTRL, 8'h71);
				wr(`FPEC_OFS_SYS_CTRL, 8'h70);
			end
			rd(`FPEC_OFS_FAULT_STAT, 8'h00);
		end
	endtask

	task automatic tally_and_finish();
		$display("Comparisons %0d, mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	initial
	begin
		#1500000;
		fails++;
		tally_and_finish();
	end

	initial
	begin
		clk_sys = 1'b0;
		resetn = 1'b0;
		hw_write_enable = 1'b0;
		wdt_resetn = 1'b1;
		cpu_evt = '0;
		flash_addr = 17'h00000;
		awaddr = 8'h00;
		awvalid = 1'b0;
		wdata = 32'h00000000;
		wstrb = 4'hF;
		wvalid = 1'b0;
		bready = 1'b0;
		araddr = 8'h00;
		arvalid = 1'b0;
		rready = 1'b0;
		fails = 0;
		cmp_count = 0;
		repeat (8) @(posedge clk_sys);
		resetn <= 1'b1;
		pin_wait();
		t_reset_and_map();
		t_mode_gating();
		t_block_select();
		t_fault_events();
		tally_and_finish();
	end
endmodule // test_flash_program_erase_control
